// ### logic/crtco_params.svh
`ifndef CRTCO_PARAMS_SVH
`define CRTCO_PARAMS_SVH

// ----------------------------------------
// Opcode patterns
// ----------------------------------------
`define CRTCO_CALL2_MASK 10'h380
`define CRTCO_CALL2_VAL 10'h100
`define CRTCO_LONG_MASK 10'h3F0
`define CRTCO_LONG_VAL 10'h070
`define CRTCO_OP_LONG_IND 10'h050
`define CRTCO_OP_RET 10'h044
`define CRTCO_OP_RET_SKIP 10'h045
`define CRTCO_OP_RD_TMR 10'h057
`define CRTCO_OP_LD_TMR 10'h047
`define CRTCO_OP_WR_TCTL 10'h05B
`define CRTCO_OP_TST_FLAG 10'h042
`define CRTCO_OP_RD_CCTL 10'h040
`define CRTCO_OP_WR_CCTL 10'h05A
`define CRTCO_OP_SET_CARR 10'h086

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define CRTCO_PAGE_TWO 3'h2
`define CRTCO_RUN_BIT 0
`define CRTCO_PC_RST 10'h000
`define CRTCO_SP_RST 3'h0
`define CRTCO_TMR_RST 8'hFF
`define CRTCO_CTL_RST 3'h0

`endif

// ### logic/crtco_pkg.sv
package crtco_pkg;

	typedef enum logic [1:0] {ST_EXEC, ST_OPERAND, ST_RET_WAIT} crtco_state_e;

	typedef struct packed {
		logic a_we;
		logic [3:0] a;
		logic b_we;
		logic [3:0] b;
	} crtco_acc_wr_s;

	typedef struct packed {
		crtco_state_e st;
		logic [9:0] pc;
		logic [2:0] sp;
		logic [7:0][9:0] stk;
		logic skip;
		logic ind;
		logic [2:0] page;
		logic [2:0] tctl;
		logic [2:0] cctl;
		logic carr;
		crtco_acc_wr_s wr;
	} crtco_core_s;

	typedef struct packed {
		logic [7:0] cnt;
		logic [7:0] rel;
		logic flag;
	} crtco_tmr_s;

endpackage : crtco_pkg

// ### logic/crtco_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "crtco_params.svh"

module crtco_timer (
	input wire logic clk,
	input wire logic nrst,
	input wire logic tick,
	input wire logic run,
	input wire logic ld_rel,
	input wire logic ld_cnt,
	input wire logic [7:0] ld_val,
	input wire logic clr_flag,
	output logic [7:0] count,
	output logic flag
);
	import crtco_pkg::*;

	crtco_tmr_s t_reg;
	crtco_tmr_s t_next;

	// ----------------------------------------
	// Down counter with reload
	// ----------------------------------------
	always_comb begin
		t_next = t_reg;
		if (run && tick) begin
			if (t_reg.cnt == 8'h00) begin
				t_next.cnt = t_reg.rel;
				t_next.flag = 1'b1;
			end else begin
				t_next.cnt = t_reg.cnt - 8'h01;
			end
		end
		if (ld_rel) begin
			t_next.rel = ld_val;
		end
		if (ld_cnt) begin
			t_next.cnt = ld_val;
		end
		// Clear is blocked by an underflow in the same cycle, so the underflow is not lost
		if (clr_flag && !(run && tick && t_reg.cnt == 8'h00)) begin
			t_next.flag = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			t_reg <= '{cnt: `CRTCO_TMR_RST, rel: `CRTCO_TMR_RST, flag: 1'b0};
		end else begin
			t_reg <= t_next;
		end
	end

	assign count = t_reg.cnt;
	assign flag = t_reg.flag;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_flag_set_wins: assert property (run && tick && t_reg.cnt == 8'h00 |=> flag)
		else $error("underflow lost against flag clear");
	a_load_no_count: assert property (ld_rel && !ld_cnt && !tick |=> count == $past(count))
		else $error("running counter changed by reload write");

endmodule : crtco_timer

`default_nettype wire

// ### logic/crtco_core.sv
// Summary of operation
// - Page-two call pushes, increments pointer, jumps
// - Long call: page from word one, low word two
// - Indirect call: page p, a6-a4, A low
// - Return pops, decrements pointer, two cycles
// - Return-and-skip pops and always skips next
// - Timer read: upper to B, lower to A
// - Stopped timer: load reload and counter
// - Running timer: load reload only
// - Control write copies A bits two-zero
// - Flag test skips if set, then clears
// - Carrier control read into A bits two-zero
// - Carrier control write also clears output latch
// - Carrier output latch takes A bit three
`timescale 1ns/1ps
`default_nettype none
`include "crtco_params.svh"

module crtco_core (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [9:0] instr,
	input wire logic instr_valid,
	input wire logic [3:0] acc,
	input wire logic [3:0] breg,
	input wire logic timer_tick,
	output logic [9:0] pc,
	output logic [2:0] stack_pointer,
	output logic busy,
	output logic skip_active,
	output var crtco_pkg::crtco_acc_wr_s acc_wr,
	output logic [2:0] timer_control_reg,
	output logic [7:0] timer_count,
	output logic timer_underflow_flag,
	output logic [2:0] carrier_ctrl,
	output logic carrier_out
);
	import crtco_pkg::*;

	crtco_core_s s_reg;
	crtco_core_s s_next;
	logic go;
	logic ld_rel;
	logic ld_cnt;
	logic clr_flag;
	logic [9:0] ret_addr;
	logic timer_run_bit;

	assign timer_run_bit = s_reg.tctl[`CRTCO_RUN_BIT];
	assign ret_addr = s_reg.pc + 10'h001;
	// A skipped word is consumed as a no-op; a skipped long call loses only its first word
	assign go = (s_reg.st == ST_EXEC) && instr_valid && !s_reg.skip;

	// ----------------------------------------
	// Execution
	// ----------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.wr.a_we = 1'b0;
		s_next.wr.b_we = 1'b0;
		ld_rel = 1'b0;
		ld_cnt = 1'b0;
		clr_flag = 1'b0;
		unique case (s_reg.st)
			ST_EXEC: begin
				if (instr_valid && s_reg.skip) begin
					s_next.skip = 1'b0;
					s_next.pc = ret_addr;
				end else if (instr_valid) begin
					s_next.pc = ret_addr;
					if ((instr & `CRTCO_CALL2_MASK) == `CRTCO_CALL2_VAL) begin
						s_next.stk[s_reg.sp] = ret_addr;
						s_next.sp = s_reg.sp + 3'h1;
						s_next.pc = {`CRTCO_PAGE_TWO, instr[6:0]};
					end else if ((instr & `CRTCO_LONG_MASK) == `CRTCO_LONG_VAL) begin
						s_next.ind = 1'b0;
						s_next.page = instr[2:0];
						s_next.st = ST_OPERAND;
					end else begin
						unique case (instr)
							`CRTCO_OP_LONG_IND: begin
								s_next.ind = 1'b1;
								s_next.st = ST_OPERAND;
							end
							`CRTCO_OP_RET, `CRTCO_OP_RET_SKIP: begin
								s_next.pc = s_reg.stk[s_reg.sp - 3'h1];
								s_next.sp = s_reg.sp - 3'h1;
								s_next.skip = instr[0];
								s_next.st = ST_RET_WAIT;
							end
							`CRTCO_OP_RD_TMR: begin
								s_next.wr = '{1'b1, timer_count[3:0], 1'b1, timer_count[7:4]};
							end
							`CRTCO_OP_LD_TMR: begin
								ld_rel = 1'b1;
								ld_cnt = !timer_run_bit;
							end
							`CRTCO_OP_WR_TCTL: begin
								s_next.tctl = acc[2:0];
							end
							`CRTCO_OP_TST_FLAG: begin
								s_next.skip = timer_underflow_flag;
								clr_flag = timer_underflow_flag;
							end
							`CRTCO_OP_RD_CCTL: begin
								s_next.wr.a_we = 1'b1;
								s_next.wr.a = {acc[3], s_reg.cctl};
							end
							`CRTCO_OP_WR_CCTL: begin
								s_next.cctl = acc[2:0];
								s_next.carr = 1'b0;
							end
							`CRTCO_OP_SET_CARR: begin
								s_next.carr = acc[3];
							end
							default: begin
							end
						endcase
					end
				end
			end
			ST_OPERAND: begin
				if (instr_valid) begin
					s_next.stk[s_reg.sp] = ret_addr;
					s_next.sp = s_reg.sp + 3'h1;
					s_next.st = ST_EXEC;
					if (s_reg.ind) begin
						s_next.pc = {instr[2:0], instr[6:4], acc};
					end else begin
						s_next.pc = {s_reg.page, instr[6:0]};
					end
				end
			end
			ST_RET_WAIT: begin
				// Second return cycle fetches nothing
				s_next.st = ST_EXEC;
			end
			default: begin
				s_next.st = ST_EXEC;
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_reg <= '{st: ST_EXEC, pc: `CRTCO_PC_RST, sp: `CRTCO_SP_RST, stk: '0,
				skip: 1'b0, ind: 1'b0, page: 3'h0, tctl: `CRTCO_CTL_RST,
				cctl: `CRTCO_CTL_RST, carr: 1'b0, wr: '0};
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------
	// Timer 1
	// ----------------------------------------
	crtco_timer u_timer (
		.clk(clk),
		.nrst(nrst),
		.tick(timer_tick),
		.run(timer_run_bit),
		.ld_rel(ld_rel),
		.ld_cnt(ld_cnt),
		.ld_val({breg, acc}),
		.clr_flag(clr_flag),
		.count(timer_count),
		.flag(timer_underflow_flag)
	);

	assign pc = s_reg.pc;
	assign stack_pointer = s_reg.sp;
	assign busy = (s_reg.st != ST_EXEC);
	assign skip_active = s_reg.skip;
	assign acc_wr = s_reg.wr;
	assign timer_control_reg = s_reg.tctl;
	assign carrier_ctrl = s_reg.cctl;
	assign carrier_out = s_reg.carr;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_call_two_jump: assert property (go && (instr & `CRTCO_CALL2_MASK) == `CRTCO_CALL2_VAL
		|=> pc == {`CRTCO_PAGE_TWO, $past(instr[6:0])} && stack_pointer == $past(stack_pointer) + 3'h1)
		else $error("page-two call target or pointer wrong");
	a_long_call_two: assert property (go && (instr & `CRTCO_LONG_MASK) == `CRTCO_LONG_VAL
		##1 instr_valid |=> pc == {$past(instr[2:0], 2), $past(instr[6:0])})
		else $error("long call target wrong");
	a_ind_call_target: assert property (s_reg.st == ST_OPERAND && instr_valid && s_reg.ind
		|=> pc == {$past(instr[2:0]), $past(instr[6:4]), $past(acc)})
		else $error("indirect call target wrong");
	a_operand_word: assert property (s_reg.st == ST_OPERAND && instr_valid
		|=> !busy && stack_pointer == $past(stack_pointer) + 3'h1)
		else $error("operand word not consumed as operand");
	a_return_pop: assert property (go && instr == `CRTCO_OP_RET
		|=> busy && pc == $past(s_reg.stk[s_reg.sp - 3'h1]) ##1 !busy)
		else $error("return pop or timing wrong");
	a_return_skip: assert property (go && instr == `CRTCO_OP_RET_SKIP |=> ##1 skip_active)
		else $error("return-and-skip did not skip");
	a_timer_read: assert property (go && instr == `CRTCO_OP_RD_TMR
		|=> acc_wr.a_we && acc_wr.b_we && {acc_wr.b, acc_wr.a} == $past(timer_count))
		else $error("timer read wrong");
	a_load_stopped: assert property (go && instr == `CRTCO_OP_LD_TMR && !timer_run_bit
		|=> timer_count == {$past(breg), $past(acc)})
		else $error("stopped timer load wrong");
	a_ctrl_write: assert property (go && instr == `CRTCO_OP_WR_TCTL
		|=> timer_control_reg == $past(acc[2:0]))
		else $error("timer control write wrong");
	a_flag_test: assert property (go && instr == `CRTCO_OP_TST_FLAG
		|=> skip_active == $past(timer_underflow_flag))
		else $error("flag test skip wrong");
	a_carr_read: assert property (go && instr == `CRTCO_OP_RD_CCTL
		|=> acc_wr.a_we && acc_wr.a[2:0] == $past(carrier_ctrl))
		else $error("carrier control read wrong");
	a_carr_write: assert property (go && instr == `CRTCO_OP_WR_CCTL
		|=> carrier_ctrl == $past(acc[2:0]) && !carrier_out)
		else $error("carrier control write wrong");
	a_carr_latch: assert property (go && instr == `CRTCO_OP_SET_CARR |=> carrier_out == $past(acc[3]))
		else $error("carrier latch wrong");

	c_long_call: cover property (go && (instr & `CRTCO_LONG_MASK) == `CRTCO_LONG_VAL ##1 instr_valid);
	c_ret_skip: cover property (go && instr == `CRTCO_OP_RET_SKIP);
	c_flag_skip: cover property (go && instr == `CRTCO_OP_TST_FLAG && timer_underflow_flag);
	c_load_run: cover property (go && instr == `CRTCO_OP_LD_TMR && timer_run_bit);

endmodule : crtco_core

`default_nettype wire

// ### testbench/crtco_tb.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import crtco_pkg::*;
	logic clk;
	logic nrst;
	logic instr_valid;
	logic timer_tick;
	logic [9:0] instr;
	logic [9:0] pc;
	logic [3:0] acc;
	logic [3:0] breg;
	logic [2:0] sp;
	logic [2:0] tctl;
	logic [2:0] cctl;
	logic busy;
	logic skip;
	logic flag;
	logic carr;
	logic [7:0] cnt;
	crtco_acc_wr_s acc_wr;
	int fail_count = 0;
	int check_count = 0;

	crtco_core u_dut (
		.clk(clk),
		.nrst(nrst),
		.instr(instr),
		.instr_valid(instr_valid),
		.acc(acc),
		.breg(breg),
		.timer_tick(timer_tick),
		.pc(pc),
		.stack_pointer(sp),
		.busy(busy),
		.skip_active(skip),
		.acc_wr(acc_wr),
		.timer_control_reg(tctl),
		.timer_count(cnt),
		.timer_underflow_flag(flag),
		.carrier_ctrl(cctl),
		.carrier_out(carr)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// Tasks op, idle and pulse start and end 1 ns after a rising edge
	// Each of op, idle and pulse sets every strobe once at its start, so back-to-back calls of the same task never toggle one
	task automatic op(input logic [9:0] w, input logic [3:0] a, input logic [3:0] b);
		instr = w;
		acc = a;
		breg = b;
		instr_valid = 1'b1;
		timer_tick = 1'b0;
		@(posedge clk);
		#1;
	endtask : op

	task automatic idle;
		instr_valid = 1'b0;
		timer_tick = 1'b0;
		@(posedge clk);
		#1;
	endtask : idle

	task automatic pulse;
		instr_valid = 1'b0;
		timer_tick = 1'b1;
		@(posedge clk);
		#1;
	endtask : pulse

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : wrap_up

	// ----------------------------------------
	// Clock, watchdog
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// The whole sequence needs well under 500 cycles
	initial begin
		#20000;
		fail_count++;
		wrap_up();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		nrst = 1'b0;
		instr = 10'h000;
		instr_valid = 1'b0;
		acc = 4'h0;
		breg = 4'h0;
		timer_tick = 1'b0;
		repeat (12) @(posedge clk);
		#1;
		nrst = 1'b1;
		chk("pc", 10'h000, pc);
		chk("sp", 10'h000, sp);
		chk("count", 10'h0FF, cnt);
		chk("carrier", 10'h000, {cctl, carr, flag, tctl});
		$display("test reset done");

		op(10'h155, 4'h0, 4'h0);
		chk("pc", 10'h155, pc);
		chk("sp", 10'h001, sp);
		op(10'h077, 4'h0, 4'h0);
		chk("busy", 10'h001, busy);
		op(10'h12A, 4'h0, 4'h0);
		chk("pc", 10'h3AA, pc);
		chk("sp", 10'h002, sp);
		op(10'h044, 4'h0, 4'h0);
		chk("busy", 10'h001, busy);
		chk("pc", 10'h157, pc);
		chk("sp", 10'h001, sp);
		idle();
		op(10'h050, 4'hA, 4'h0);
		op(10'h155, 4'hA, 4'h0);
		chk("pc", 10'h2DA, pc);
		chk("sp", 10'h002, sp);
		op(10'h045, 4'h0, 4'h0);
		chk("pc", 10'h159, pc);
		chk("sp", 10'h001, sp);
		idle();
		chk("skip", 10'h001, skip);
		// A skipped control write must leave the register alone
		op(10'h05B, 4'h7, 4'h0);
		chk("skip", 10'h000, skip);
		chk("tctl", 10'h000, tctl);
		op(10'h044, 4'h0, 4'h0);
		chk("pc", 10'h001, pc);
		chk("sp", 10'h000, sp);
		idle();
		$display("test calls done");

		op(10'h047, 4'hC, 4'h3);
		chk("count", 10'h03C, cnt);
		op(10'h057, 4'h0, 4'h0);
		chk("acc_wr", {1'b1, 4'hC, 1'b1, 4'h3}, acc_wr);
		idle();
		chk("a_we", 10'h000, {acc_wr.a_we, acc_wr.b_we});
		op(10'h05B, 4'hF, 4'h0);
		chk("tctl", 10'h007, tctl);
		op(10'h05B, 4'h1, 4'h0);
		chk("tctl", 10'h001, tctl);
		op(10'h047, 4'h2, 4'h0);
		chk("count", 10'h03C, cnt);
		for (int i = 0; i < 200 && flag !== 1'b1; i++) begin
			pulse();
		end
		chk("flag", 10'h001, flag);
		chk("count", 10'h002, cnt);
		op(10'h05B, 4'h0, 4'h0);
		op(10'h042, 4'h0, 4'h0);
		chk("skip", 10'h001, skip);
		chk("flag", 10'h000, flag);
		op(10'h042, 4'h0, 4'h0);
		op(10'h042, 4'h0, 4'h0);
		chk("skip", 10'h000, skip);
		$display("test timer done");

		op(10'h05A, 4'h5, 4'h0);
		chk("cctl", 10'h005, cctl);
		op(10'h086, 4'h8, 4'h0);
		chk("carr", 10'h001, carr);
		op(10'h040, 4'h8, 4'h0);
		chk("a_we", 10'h001, acc_wr.a_we);
		chk("a", 10'h00D, acc_wr.a);
		// Bit 3 is set here, yet the latch must still be forced low
		op(10'h05A, 4'hF, 4'h0);
		chk("cctl", 10'h007, cctl);
		chk("carr", 10'h000, carr);
		op(10'h086, 4'h0, 4'h0);
		chk("carr", 10'h000, carr);
		$display("test carrier done");
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
